/* File: rie_top.sv */
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rie_defines.svh"
// Overview of operation
// - Reset loads PC 8000H and system stack pointer 100H.
// - Reset sets system mode, mask 111, minimum mode, register bank 000.
// - Reset leaves all other CPU registers untouched.
// - Reset makes ports inputs, watchdog pin low, clock out high, ALE low.
// - Strap 0: upper pins carry data, widths from chip-select config.
// - Strap 1: upper pins are address, width bits ignored, 8-bit bus.
// - Accept when offered level strictly exceeds the mask level, or is 7 (non-maskable) whatever the mask.
// - Controller offers only the highest pending level; non-maskable is 7.
// - EI num loads mask immediately; DI loads 7.
// - Accept reads vector, ties go to smaller vector, request cleared.
// - Push PC and status onto the system stack.
// - Mask becomes accepted level plus one, but 7 stays 7.
// - Entry sets system mode.
// - Branch to 8000H plus vector.
// - Entry lasts 23/19 states with 8-bit stack, 17/15 with 16-bit.
// - Return pops PC and status, restoring the old mask.
// - Non-maskable sources fixed at 7; maskable ones programmable.
// - All entry points lie in 008000H to 0081FFH.
// - Non-maskable vectors step by 10H, NMI pin at 8080H then watchdog.
// - Each maskable source has a fixed vector; its code is vector/16.
// - Six programmable levels per maskable source, reported to the CPU.
module rie_top
    import rie_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire rie_pkg::rie_bus_t busReq,
    output logic [31:0]            rdData,
    input  wire logic [20:0]       irqPins,
    input  wire logic              busWidthPin,
    input  wire logic              stackBus16,
    input  wire rie_pkg::rie_instr_t instr,
    input  wire logic              privFault,
    input  wire logic              illegalOp,
    output logic [23:0]            pcOut,
    output logic [23:0]            xspOut,
    output logic [15:0]            srOut,
    output logic                   entryBusy,
    output logic                   branchOut,
    output rie_pkg::rie_push_t     pushOut,
    output rie_pkg::rie_pins_t     pinsOut
);
    import rie_pkg::*;

    typedef struct packed {
        rie_fsm_t        fsm;
        logic [23:0]     pc;
        logic [23:0]     system_stack_pointer;
        logic            system_mode_flag;
        logic [2:0]      mask;
        logic            maxm;
        logic [2:0]      rfp;
        logic [20:0]     pend;
        logic [20:0][2:0] prio;
        logic [3:0]      csBus;
        logic            strap;
        logic            strapDone;
        logic [1:0]      strapCnt;
        logic [4:0]      code;
        logic [2:0]      lvl;
        logic [4:0]      idx;
        logic            isIrq;
        logic [4:0]      cnt;
        logic [1:0]      clkDiv;
        logic [21:0]     syncA;
        logic [21:0]     syncB;
        logic [20:0]     prevB;
        logic            branch;
        logic [31:0]     rdata;
        rie_push_t       push;
        rie_pins_t       pins;
        logic            busy;
    } rie_state_t;

    rie_state_t  st_r;
    rie_state_t  st_nxt;
    logic [31:0] gpReg_r;
    logic [20:0] newEdge;
    logic [2:0]  bestLvl;
    logic [4:0]  bestIdx;
    logic [4:0]  total;
    logic        hasInstr;

    // ------------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------------
    // Source 0 is the NMI pin, 1 the watchdog, 2 up the maskable ones.
    // The reserved codes 0FH, 16H and 17H have no index, so they can
    // never be offered.
    function automatic logic [4:0] srcCode(input int unsigned i);
        if (i < 32'h7) begin
            srcCode = 5'(32'h8 + i);
        end else if (i < 32'hD) begin
            srcCode = 5'(32'h10 + i - 32'h7);
        end else begin
            srcCode = 5'(32'h18 + i - 32'hD);
        end
    endfunction : srcCode

    function automatic logic [15:0] srOf(input rie_state_t s);
        srOf = {s.system_mode_flag, s.mask, s.maxm, s.rfp, 8'h00};
    endfunction : srOf

    // ------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------
    // Strict compare while scanning upward gives ties to the smaller
    // vector. Levels 0 and 7 written to a maskable slot disable it.
    always_comb begin
        bestLvl = 3'h0;
        bestIdx = 5'h00;
        for (int i = 0; i < `RIE_NSRC; i++) begin
            logic [2:0] l;
            l = 3'h0;
            if (i < 2) begin
                l = `RIE_LVL_NMI;
            end else if (st_r.prio[i] != 3'h0 && st_r.prio[i] != 3'h7) begin
                l = st_r.prio[i];
            end
            if (st_r.pend[i] && l > bestLvl) begin
                bestLvl = l;
                bestIdx = 5'(i);
            end
        end
    end

    // Entry length depends on mode and on the stack area width.
    assign total = st_r.maxm ? (stackBus16 ? `RIE_ST_MAX16 : `RIE_ST_MAX8)
                             : (stackBus16 ? `RIE_ST_MIN16 : `RIE_ST_MIN8);

    assign newEdge  = st_r.syncB[20:0] & ~st_r.prevB;
    assign hasInstr = (instr.op != OP_NONE) || privFault || illegalOp;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [20:0] clr;
        st_nxt = st_r;
        clr = 21'h000000;
        st_nxt.push.valid = 1'b0;
        st_nxt.branch = 1'b0;
        st_nxt.rdata = 32'h00000000;
        // Two flops on every pin; only the second is looked at.
        st_nxt.syncA = {busWidthPin, irqPins};
        st_nxt.syncB = st_r.syncA;
        st_nxt.prevB = st_r.syncB[20:0];
        st_nxt.clkDiv = st_r.clkDiv + 2'h1;
        st_nxt.pins.clkOut = st_r.clkDiv[1];
        // The strap is taken once the synchroniser has settled.
        if (!st_r.strapDone) begin
            st_nxt.strapCnt = st_r.strapCnt + 2'h1;
            if (st_r.strapCnt == 2'h2) begin
                st_nxt.strap = st_r.syncB[21];
                st_nxt.strapDone = 1'b1;
            end
        end
        st_nxt.pins.upperAddr = st_r.strap;
        st_nxt.pins.bus16 = st_r.strap ? 4'h0 : st_r.csBus;
        st_nxt.pins.ale = 1'b0;

        // Register writes.
        if (busReq.wr) begin
            if (busReq.addr == `RIE_A_XSP) begin
                st_nxt.system_stack_pointer = busReq.wdata[23:0];
            end else if (busReq.addr == `RIE_A_PEND) begin
                clr = busReq.wdata[20:0];
            end else if (busReq.addr == `RIE_A_PINS) begin
                st_nxt.pins.portsInput = busReq.wdata[`RIE_PIN_PORTIN];
                st_nxt.pins.wdt = busReq.wdata[`RIE_PIN_WDT];
            end else if (busReq.addr[7:2] == `RIE_A_CS0 >> 2) begin
                st_nxt.csBus[busReq.addr[1:0]] = busReq.wdata[`RIE_CS_WIDTH];
            end else if (busReq.addr >= `RIE_A_PRIO0 &&
                         busReq.addr < `RIE_A_PRIO0 + 8'(`RIE_NSRC)) begin
                st_nxt.prio[5'(busReq.addr - `RIE_A_PRIO0)] = busReq.wdata[2:0];
            end
        end

        // Register reads, answered in the next cycle only.
        if (busReq.rd) begin
            case (busReq.addr)
                `RIE_A_SR:   st_nxt.rdata = {16'h0000, srOf(st_r)};
                `RIE_A_PC:   st_nxt.rdata = {8'h00, st_r.pc};
                `RIE_A_XSP:  st_nxt.rdata = {8'h00, st_r.system_stack_pointer};
                `RIE_A_PEND: st_nxt.rdata = {11'h000, st_r.pend};
                `RIE_A_PINS: st_nxt.rdata = {24'h000000, st_r.pins.bus16, 1'b0,
                                st_r.strap, st_r.pins.wdt, st_r.pins.portsInput};
                `RIE_A_GP:   st_nxt.rdata = gpReg_r;
                default: begin
                    if (busReq.addr[7:2] == `RIE_A_CS0 >> 2) begin
                        st_nxt.rdata[`RIE_CS_WIDTH] = st_r.csBus[busReq.addr[1:0]];
                    end else if (busReq.addr >= `RIE_A_PRIO0 + 8'h02 &&
                                 busReq.addr < `RIE_A_PRIO0 + 8'(`RIE_NSRC)) begin
                        st_nxt.rdata[2:0] = st_r.prio[5'(busReq.addr - `RIE_A_PRIO0)];
                    end else if (busReq.addr >= `RIE_A_PRIO0 &&
                                 busReq.addr < `RIE_A_PRIO0 + 8'h02) begin
                        st_nxt.rdata[2:0] = `RIE_LVL_NMI;
                    end
                end
            endcase
        end

        // Entry sequencer. Instructions are ignored while an entry runs.
        if (st_r.cnt != 5'h00) begin
            st_nxt.cnt = st_r.cnt - 5'h01;
        end
        case (st_r.fsm)
            ST_IDLE: begin
                if (hasInstr) begin
                    if (instr.op == OP_EI) begin
                        st_nxt.mask = instr.arg;
                    end else if (instr.op == OP_DI) begin
                        st_nxt.mask = 3'h7;
                    end else if (instr.op == OP_RETURN_FROM_INTERRUPT_INSTR) begin
                        st_nxt.pc = instr.popPc;
                        st_nxt.system_mode_flag = instr.popSr[15];
                        st_nxt.mask = instr.popSr[14:12];
                        st_nxt.maxm = instr.popSr[11];
                        st_nxt.rfp = instr.popSr[10:8];
                        st_nxt.system_stack_pointer = st_r.system_stack_pointer + 24'h000006;
                    end else begin
                        // Traps are non-maskable and bypass the compare.
                        st_nxt.code = privFault ? `RIE_CODE_PRIV :
                                      illegalOp ? `RIE_CODE_UNDEF :
                                      {2'h0, instr.arg};
                        st_nxt.lvl = `RIE_LVL_NMI;
                        st_nxt.isIrq = 1'b0;
                        st_nxt.cnt = total - 5'h01;
                        st_nxt.fsm = ST_VEC;
                    end
                end else if (bestLvl > st_r.mask ||
                             bestLvl == `RIE_LVL_NMI) begin
                    st_nxt.code = srcCode(32'(bestIdx));
                    st_nxt.lvl = bestLvl;
                    st_nxt.idx = bestIdx;
                    st_nxt.isIrq = 1'b1;
                    st_nxt.cnt = total - 5'h01;
                    st_nxt.fsm = ST_VEC;
                end
            end
            ST_VEC: begin
                if (st_r.isIrq) begin
                    clr[st_r.idx] = 1'b1;
                end
                st_nxt.fsm = ST_PUSHPC;
            end
            ST_PUSHPC: begin
                st_nxt.push = {1'b1, 1'b1, st_r.system_stack_pointer - 24'h000004, st_r.pc};
                st_nxt.system_stack_pointer = st_r.system_stack_pointer - 24'h000004;
                st_nxt.fsm = ST_PUSHSR;
            end
            ST_PUSHSR: begin
                st_nxt.push = {1'b1, 1'b0, st_r.system_stack_pointer - 24'h000002,
                               8'h00, srOf(st_r)};
                st_nxt.system_stack_pointer = st_r.system_stack_pointer - 24'h000002;
                st_nxt.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                if (st_r.cnt == 5'h01) begin
                    st_nxt.pc = `RIE_ENTRY_BASE + {15'h0000, st_r.code, 4'h0};
                    st_nxt.system_mode_flag = 1'b1;
                    st_nxt.mask = (st_r.lvl == 3'h7) ? 3'h7 : st_r.lvl + 3'h1;
                    st_nxt.branch = 1'b1;
                    st_nxt.fsm = ST_IDLE;
                end
            end
            default: st_nxt.fsm = ST_IDLE;
        endcase
        // A new request in the same cycle as its clear survives.
        st_nxt.pend = (st_r.pend & ~clr) | newEdge;
        // Busy is kept in a flop so that the output pin needs no decode.
        st_nxt.busy = (st_nxt.fsm != ST_IDLE);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.fsm <= ST_IDLE;
            st_r.pc <= `RIE_PC_RST;
            st_r.system_stack_pointer <= `RIE_XSP_RST;
            st_r.system_mode_flag <= 1'b1;
            st_r.mask <= `RIE_MASK_RST;
            st_r.maxm <= 1'b0;
            st_r.rfp <= `RIE_RFP_RST;
            st_r.pins.portsInput <= 1'b1;
            st_r.pins.wdt <= 1'b0;
            st_r.pins.clkOut <= 1'b1;
            st_r.pins.ale <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The general register stands for CPU state that reset must not
    // touch, so it has no reset at all and reads unknown until written.
    always_ff @(posedge ref_clk) begin
        if (busReq.wr && busReq.addr == `RIE_A_GP) begin
            gpReg_r <= busReq.wdata;
        end
    end

    // Outputs come straight from the state register.
    assign rdData    = st_r.rdata;
    assign pcOut     = st_r.pc;
    assign xspOut    = st_r.system_stack_pointer;
    assign srOut     = {st_r.system_mode_flag, st_r.mask, st_r.maxm, st_r.rfp, 8'h00};
    assign entryBusy = st_r.busy;
    assign branchOut = st_r.branch;
    assign pushOut   = st_r.push;
    assign pinsOut   = st_r.pins;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [4:0] cyc_r;
    logic [4:0] totL_r;
    logic       accept;
    assign accept = (st_r.fsm == ST_IDLE) && (st_nxt.fsm == ST_VEC);

    // Counts states from acceptance to the branch.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_r <= 5'h00;
            totL_r <= 5'h00;
        end else if (accept) begin
            cyc_r <= 5'h01;
            totL_r <= total;
        end else if (cyc_r != 5'h00) begin
            cyc_r <= cyc_r + 5'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    reset_pc_a: assert property ($past(sys_rst) |->
        pcOut == `RIE_PC_RST && xspOut == `RIE_XSP_RST)
        else $error("PC or stack pointer wrong after reset.");
    reset_sr_a: assert property ($past(sys_rst) |->
        srOut[15:8] == 8'hF0)
        else $error("Status fields wrong after reset.");
    strict_accept_a: assert property ((st_r.fsm == ST_IDLE && !hasInstr &&
        bestLvl <= st_r.mask && bestLvl != `RIE_LVL_NMI) |=> st_r.fsm == ST_IDLE)
        else $error("Interrupt taken at or below the mask.");
    nmi_take_a: assert property ((st_r.fsm == ST_IDLE && !hasInstr &&
        bestLvl == `RIE_LVL_NMI) |=> st_r.fsm == ST_VEC)
        else $error("Non-maskable request not taken.");
    mask_raise_a: assert property (branchOut |->
        st_r.mask == ((st_r.lvl == 3'h7) ? 3'h7 : st_r.lvl + 3'h1))
        else $error("Mask not raised correctly on entry.");
    entry_mode_a: assert property (branchOut |-> st_r.system_mode_flag)
        else $error("Entry left user mode set.");
    entry_addr_a: assert property (branchOut |->
        pcOut == `RIE_ENTRY_BASE + {15'h0000, st_r.code, 4'h0} &&
        pcOut <= `RIE_ENTRY_LAST)
        else $error("Branch target wrong.");
    entry_time_a: assert property (branchOut |-> cyc_r == totL_r)
        else $error("Entry took the wrong number of states.");
    vector_clear_a: assert property ((st_r.fsm == ST_VEC && st_r.isIrq &&
        !newEdge[st_r.idx]) |=> !st_r.pend[$past(st_r.idx)])
        else $error("Accepted request not cleared.");
    set_wins_a: assert property ((|newEdge) |=>
        ((st_r.pend & $past(newEdge)) == $past(newEdge)))
        else $error("Request lost against a clear.");
    ei_level_a: assert property ((st_r.fsm == ST_IDLE && instr.op == OP_EI)
        |=> st_r.mask == $past(instr.arg))
        else $error("EI did not load the mask.");
    strap_eight_a: assert property ((st_r.strap && st_r.strapDone)
        |=> pinsOut.bus16 == 4'h0 && pinsOut.upperAddr)
        else $error("Width bits not ignored with 8-bit strap.");

    irq_entry_c: cover property (accept && st_nxt.isIrq ##[15:23] branchOut);
    trap_entry_c: cover property (accept && !st_nxt.isIrq);
    nested_c: cover property (accept && st_r.mask != 3'h7 && st_r.system_mode_flag);
    return_from_interrupt_instr_c: cover property (st_r.fsm == ST_IDLE && instr.op == OP_RETURN_FROM_INTERRUPT_INSTR);
endmodule : rie_top

/* File: rie_defines.svh */
`ifndef RIE_DEFINES_SVH
`define RIE_DEFINES_SVH
// ----------------------------------------------------------------------
// Reset values, non-maskable level and entry range
// ----------------------------------------------------------------------
`define RIE_PC_RST      24'h008000
`define RIE_XSP_RST     24'h000100
`define RIE_MASK_RST    3'h7
`define RIE_RFP_RST     3'h0
`define RIE_LVL_NMI     3'h7
`define RIE_ENTRY_BASE  24'h008000
`define RIE_ENTRY_LAST  24'h0081FF
// ----------------------------------------------------------------------
// Entry timing in system clock states
// ----------------------------------------------------------------------
`define RIE_ST_MAX8     5'h17
`define RIE_ST_MIN8     5'h13
`define RIE_ST_MAX16    5'h11
`define RIE_ST_MIN16    5'h0F
// ----------------------------------------------------------------------
// Sources, trap codes and field positions
// ----------------------------------------------------------------------
`define RIE_NSRC        21
`define RIE_CODE_PRIV   5'h01
`define RIE_CODE_UNDEF  5'h02
`define RIE_CS_WIDTH    4
`define RIE_PIN_PORTIN  0
`define RIE_PIN_WDT     1
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RIE_A_SR        8'h00
`define RIE_A_PC        8'h01
`define RIE_A_XSP       8'h02
`define RIE_A_PEND      8'h03
`define RIE_A_PINS      8'h04
`define RIE_A_GP        8'h05
`define RIE_A_CS0       8'h08
`define RIE_A_PRIO0     8'h10
`endif

/* File: rie_pkg.sv */
package rie_pkg;
`include "rie_defines.svh"
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, ST_VEC = 5'h02, ST_PUSHPC = 5'h04,
        ST_PUSHSR = 5'h08, ST_WAIT = 5'h10
    } rie_fsm_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_EI = 3'h1, OP_DI = 3'h2, OP_RETURN_FROM_INTERRUPT_INSTR = 3'h3, OP_SWI = 3'h4
    } rie_op_t;
    typedef struct packed {
        rie_op_t     op;
        logic [2:0]  arg;
        logic [23:0] popPc;
        logic [15:0] popSr;
    } rie_instr_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rie_bus_t;
    typedef struct packed {
        logic        valid;
        logic        word32;
        logic [23:0] addr;
        logic [23:0] data;
    } rie_push_t;
    typedef struct packed {
        logic       portsInput;
        logic       wdt;
        logic       clkOut;
        logic       ale;
        logic       upperAddr;
        logic [3:0] bus16;
    } rie_pins_t;
endpackage : rie_pkg

/* File: rie_stack_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// System stack memory seen by the entry logic
// ----------------------------------------------------------------------
module rie_stack_model
    import rie_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire rie_pkg::rie_push_t pushIn,
    input  wire logic [23:0]       xspIn,
    output logic [23:0]            popPc,
    output logic [15:0]            popSr
);
    import rie_pkg::*;
    logic [23:0] stackMem [0:255];
    logic [23:0] pcAddr;

    // A slot never written reads all ones rather than a value that could match.
    initial begin
        for (int i = 0; i < 256; i++) begin
            stackMem[i] = 24'hFFFFFF;
        end
    end

    // Every pushed frame word is stored at the halfword address that the push names.
    always @(posedge ref_clk) begin
        if (pushIn.valid === 1'b1) begin
            stackMem[pushIn.addr[8:1]] <= pushIn.data;
        end
    end

    // The frame at the stack top feeds the return; status sits below the PC.
    // Only the low 512 bytes are modelled, which holds every frame used here.
    assign pcAddr = xspIn + 24'h000002;
    assign popSr  = stackMem[xspIn[8:1]][15:0];
    assign popPc  = stackMem[pcAddr[8:1]];
endmodule : rie_stack_model

/* File: testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Reset and interrupt entry testbench
// ----------------------------------------------------------------------
module testbench;
    import rie_pkg::*;
    logic        ref_clk, sys_rst, busWidthPin, stackBus16, privFault, illegalOp;
    logic        entryBusy, branchOut;
    rie_bus_t    busReq;
    rie_instr_t  instr;
    rie_push_t   pushOut;
    rie_pins_t   pinsOut;
    logic [20:0] irqPins;
    logic [31:0] rdData;
    logic [23:0] pcOut, xspOut, popPc;
    logic [15:0] srOut, popSr;
    int          bad_count, checks, cyc;

    rie_top u_rie_top (.ref_clk, .sys_rst, .busReq, .rdData, .irqPins, .busWidthPin,
        .stackBus16, .instr, .privFault, .illegalOp, .pcOut, .xspOut, .srOut,
        .entryBusy, .branchOut, .pushOut, .pinsOut);
    rie_stack_model u_rie_stack_model (.ref_clk, .pushIn(pushOut), .xspIn(xspOut),
        .popPc, .popSr);

    // Free-running system clock, one state per period.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        busReq <= '0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe, so look there.
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        busReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        busReq <= '0;
        #1;
    endtask : rd

    task automatic op(input rie_op_t o, input logic [2:0] a);
        @(posedge ref_clk);
        instr <= '{o, a, popPc, popSr};
        @(posedge ref_clk);
        instr <= '0;
        @(negedge ref_clk);
    endtask : op

    // Entry length is counted from the first busy cycle to the branch pulse.
    task automatic entry(input int t, input logic [23:0] pc, input logic [15:0] sr);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (entryBusy !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        while (branchOut !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, t - 1);
        chk(pcOut, pc);
        chk(srOut, sr);
    endtask : entry

    task automatic tally_and_finish;
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        busReq = '0;
        instr = '0;
        irqPins = '0;
        busWidthPin = 1'b1;
        stackBus16 = 1'b1;
        privFault = 1'b0;
        illegalOp = 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(pcOut, 32'h8000);
        chk(xspOut, 32'h100);
        chk(srOut, 32'hF000);
        chk({pinsOut.portsInput, pinsOut.wdt, pinsOut.clkOut, pinsOut.ale}, 4'hA);
        sys_rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        wr(8'h08, 32'h10);
        rd(8'h04);
        chk({rdData[7:4], rdData[2]}, 5'h01);
        chk({pinsOut.upperAddr, pinsOut.bus16}, 5'h10);
        rd(8'hFF);
        chk(rdData, 32'h0);
        op(OP_EI, 3'h3);
        chk(srOut, 16'hB000);
        wr(8'h1D, 32'h3);
        @(posedge ref_clk);
        irqPins[13] <= 1'b1;
        repeat (10) @(negedge ref_clk);
        chk(entryBusy, 1'b0);
        rd(8'h03);
        chk(rdData[13], 1'b1);
        op(OP_EI, 3'h2);
        entry(15, 24'h008180, 16'hC000);
        chk(xspOut, 32'hFA);
        rd(8'h03);
        chk(rdData[13], 1'b0);
        op(OP_RETURN_FROM_INTERRUPT_INSTR, 3'h0);
        chk(srOut, 16'hA000);
        chk(xspOut, 32'h100);
        op(OP_DI, 3'h0);
        chk(srOut[14:12], 3'h7);
        @(posedge ref_clk);
        stackBus16 <= 1'b0;
        irqPins[0] <= 1'b1;
        entry(19, 24'h008080, 16'hF000);
        @(posedge ref_clk);
        illegalOp <= 1'b1;
        @(posedge ref_clk);
        illegalOp <= 1'b0;
        entry(19, 24'h008020, 16'hF000);
        // Second reset in mid-run; the general register must survive it.
        wr(8'h05, 32'h5A5AA5A5);
        @(posedge ref_clk);
        irqPins <= '0;
        busWidthPin <= 1'b0;
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk(pcOut, 32'h8000);
        chk(xspOut, 32'h100);
        chk(srOut, 32'hF000);
        sys_rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(8'h05);
        chk(rdData, 32'h5A5AA5A5);
        wr(8'h08, 32'h10);
        rd(8'h04);
        chk({rdData[7:4], rdData[2]}, 5'h02);
        chk({pinsOut.upperAddr, pinsOut.bus16}, 5'h01);
        // Two equal levels at once: the smaller vector goes first.
        wr(8'h12, 32'h4);
        wr(8'h13, 32'h4);
        op(OP_EI, 3'h0);
        @(posedge ref_clk);
        irqPins[3:2] <= 2'h3;
        entry(19, 24'h0080A0, 16'hD000);
        op(OP_RETURN_FROM_INTERRUPT_INSTR, 3'h0);
        chk(pcOut, 24'h008000);
        entry(19, 24'h0080B0, 16'hD000);
        tally_and_finish();
    end
endmodule : testbench
